// ### rtl/ucc_pkg.sv
/*
  Package for the serial control/configuration block: register offsets,
  field positions, reset values, mode encodings and the config carrier.
  Assumes a byte-wide register port with byte offsets.
*/
package ucc_pkg;
  localparam logic [3:0] OFS_INT_LINE = 4'h5;
  localparam logic [3:0] OFS_ENA_MODE = 4'h6;
  localparam logic [3:0] OFS_FRAME = 4'h7;
  localparam logic [3:0] OFS_STATE = 4'h8;

  localparam logic [7:0] RST_INT_LINE = 8'h00;
  localparam logic [7:0] RST_ENA_MODE = 8'h00;
  localparam logic [7:0] RST_FRAME_ASYNC = 8'h03;
  localparam logic [7:0] RST_FRAME_SPI = 8'h00;

  // interrupt_and_line_control fields
  localparam int B_RXC_IE = 7;
  localparam int B_TXC_IE = 6;
  localparam int B_DRE_IE = 5;
  localparam int B_SF_IE = 4;
  localparam int B_LOOP = 3;
  localparam int B_ABE_IE = 2;
  localparam int B_HD_HI = 1;
  localparam int B_HD_LO = 0;
  // enable_and_receiver_mode_control fields
  localparam int B_RX_ON = 7;
  localparam int B_TX_ON = 6;
  localparam int B_SFD_EN = 4;
  localparam int B_OD_EN = 3;
  localparam int B_RXM_HI = 2;
  localparam int B_RXM_LO = 1;
  localparam int B_MP_EN = 0;
  // frame format fields
  localparam int B_CM_HI = 7;
  localparam int B_CM_LO = 6;
  localparam int B_PAR_HI = 5;
  localparam int B_PAR_LO = 4;
  localparam int B_STOP = 3;
  localparam int B_CS_HI = 2;
  localparam int B_CS_LO = 0;
  localparam int B_ORDER = 2;
  localparam int B_PHASE = 1;

  localparam logic [7:0] MASK_ENA_MODE = 8'hDF;
  localparam logic [7:0] MASK_FRAME_SPI = 8'hC6;

  typedef enum logic [1:0] {
    UCC_RXM_NORMAL = 2'h0,
    UCC_RXM_DOUBLE = 2'h1,
    UCC_RXM_GENERIC = 2'h2,
    UCC_RXM_CONSTR = 2'h3
  } ucc_rxm_e;

  typedef enum logic [1:0] {
    UCC_CM_ASYNC = 2'h0,
    UCC_CM_SYNC = 2'h1,
    UCC_CM_INFRARED = 2'h2,
    UCC_CM_MASTER_SPI_MODE = 2'h3
  } ucc_cm_e;

  localparam logic [1:0] PAR_OFF = 2'h0;
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD = 2'h3;

  localparam logic [2:0] CS_5 = 3'h0;
  localparam logic [2:0] CS_8 = 3'h3;
  localparam logic [2:0] CS_9L = 3'h6;
  localparam logic [2:0] CS_9H = 3'h7;

  localparam logic [4:0] DIV_NORMAL = 5'h10;
  localparam logic [4:0] DIV_DOUBLE = 5'h08;
  localparam logic [3:0] DIV_SYNC = 4'h1;

  localparam logic [5:0] SYNC_PAIR_NOM = 6'h20;
  localparam logic [5:0] SYNC_PAIR_TOL = 6'h06;
  localparam logic [7:0] SYNC_VALUE = 8'h55;
  localparam logic [3:0] SYNC_BITS = 4'h8;

  // decoded configuration handed to the shift engines
  typedef struct packed {
    logic rx_on;
    logic tx_on;
    logic loopback_en;
    logic multiproc_filter_en;
    ucc_rxm_e receiver_speed_mode;
    ucc_cm_e comm_mode;
    logic [1:0] parity_select;
    logic stop_bit_count;
    logic [2:0] char_size;
    logic [3:0] data_bits;
    logic nine_bit_high_first;
    logic spi_bit_order;
    logic spi_clock_phase;
    logic [4:0] baud_divisor;
  } ucc_cfg_s;

  // irq requests per vector
  typedef struct packed {
    logic receive_vector;
    logic transmit_done_vector;
    logic tx_empty_vector;
  } ucc_irq_s;
endpackage : ucc_pkg

// ### rtl/ucc_top.sv
/*
  Control and configuration logic of a serial receiver/transmitter:
  control registers, interrupt request gating, loop-back, half-duplex
  direction control, open-drain pin, wake detection, enable sequencing
  and sync-character checking. Assumes the shift engines sit outside
  and report their flags and busy state synchronously on ref_clk.
*/
// Functional notes
// - receive-complete flag with its enable requests the receive vector.
// - transmit-complete flag with its enable requests the transmit-done vector.
// - transmit-buffer-empty flag with its enable requests its own vector.
// - detected start of frame with its enable requests the receive vector.
// - loop-back feeds transmit output to receiver, external receive pin ignored.
// - bad-sync flag with auto-baud error enable requests the receive vector.
// - half-duplex low bit drives direction pin high a cycle before sending.
// - half-duplex high bit makes transmit pin output a cycle before sending.
// - receiver off flushes buffer, error flags; resets auto-baud logic.
// - transmitter off takes effect once shifter and buffer are empty.
// - start detection wakes system on receive line falling edge.
// - open-drain mode only pulls the pin low, releases for one.
// - receiver mode codes; double speed divisor 8 instead of 16, async only.
// - generic auto-baud accepts sync after eight alternating bits.
// - constrained auto-baud needs each bit pair 32 +/- 6 samples, value 0x55.
// - multiprocessor mode makes receiver drop frames without address info.
// - communication mode codes; master SPI switches frame register layout.
// - parity off, even or odd; transmit appends, receive flags mismatch.
// - stop-bit setting gives one or two stop bits, transmitter only.
// - character size 5 to 8 bits, nine low- or high-first, 4 and 5 reserved.
// - master SPI bit order 0 sends most significant bit first.
// - master SPI bit order 1 sends least significant bit first.
// - master SPI clock phase picks leading or trailing sample edge.
`timescale 1ns/1ns
module ucc_top #(
  parameter int SAMPLE_W = 6
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // status flags from the shift engines
  input wire logic rx_complete_flag,
  input wire logic tx_complete_flag,
  input wire logic tx_empty_flag,
  input wire logic bad_sync_flag,
  input wire logic tx_shift_busy,
  input wire logic tx_start,
  input wire logic tx_done,
  input wire logic tx_serial,
  // received frame and sync measurement
  input wire logic rx_frame_valid,
  input wire logic rx_frame_addr,
  input wire logic sync_bit_pair,
  input wire logic [SAMPLE_W-1:0] sync_pair_samples,
  input wire logic sync_char_valid,
  input wire logic [7:0] sync_char,
  // line pins
  input wire logic rx_pin,
  input wire logic tx_pin_in,
  output logic tx_pin_out,
  output logic tx_pin_oe,
  output logic tx_direction_pin,
  // engine-facing outputs
  output logic rx_line,
  output logic rx_flush,
  output logic autobaud_reset,
  output logic rx_frame_accept,
  output logic sync_ok,
  output logic sync_bad,
  output logic wake_req,
  output ucc_pkg::ucc_cfg_s cfg,
  output ucc_pkg::ucc_irq_s irq
);
  logic [7:0] ctla_q;
  logic [7:0] ctlb_q;
  logic [7:0] frm_async_q;
  logic [7:0] frm_spi_q;
  logic tx_active_q;
  logic tx_was_q;
  logic rx_prev_q;
  logic [3:0] sync_cnt_q;
  logic pair_err_q;
  logic master_spi_mode;
  logic rx_src;
  logic tx_eff;
  logic tx_drive;
  logic autobaud;
  logic [7:0] frm_view;
  logic [5:0] pair_diff;

  localparam int B_CM_HI_L = ucc_pkg::B_CM_HI;
  localparam int B_CM_LO_L = ucc_pkg::B_CM_LO;
  assign master_spi_mode = (frm_async_q[B_CM_HI_L:B_CM_LO_L] == ucc_pkg::UCC_CM_MASTER_SPI_MODE);
  assign frm_view = master_spi_mode ? frm_spi_q : frm_async_q;
  assign autobaud = ctlb_q[ucc_pkg::B_RXM_HI];

  // register writes
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctla_q <= ucc_pkg::RST_INT_LINE;
      ctlb_q <= ucc_pkg::RST_ENA_MODE;
      frm_async_q <= ucc_pkg::RST_FRAME_ASYNC;
      frm_spi_q <= ucc_pkg::RST_FRAME_SPI;
    end else if (reg_wr) begin
      case (reg_addr)
        ucc_pkg::OFS_INT_LINE: ctla_q <= reg_wdata;
        ucc_pkg::OFS_ENA_MODE: ctlb_q <= reg_wdata & ucc_pkg::MASK_ENA_MODE;
        ucc_pkg::OFS_FRAME: begin
          // mode field shared by both layouts
          frm_async_q[B_CM_HI_L:B_CM_LO_L] <= reg_wdata[B_CM_HI_L:B_CM_LO_L];
          frm_spi_q <= reg_wdata & ucc_pkg::MASK_FRAME_SPI;
          if (reg_wdata[B_CM_HI_L:B_CM_LO_L] != ucc_pkg::UCC_CM_MASTER_SPI_MODE) begin
            frm_async_q[ucc_pkg::B_PAR_HI:ucc_pkg::B_CS_LO] <=
              reg_wdata[ucc_pkg::B_PAR_HI:ucc_pkg::B_CS_LO];
          end
        end
        default: ;
      endcase
    end
  end

  // register reads, data in the following cycle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        ucc_pkg::OFS_INT_LINE: reg_rdata <= ctla_q;
        ucc_pkg::OFS_ENA_MODE: reg_rdata <= {ctlb_q[7], tx_eff, ctlb_q[5:0]};
        ucc_pkg::OFS_FRAME: reg_rdata <= frm_view;
        ucc_pkg::OFS_STATE: reg_rdata <= {2'h0, sync_cnt_q, tx_active_q, tx_drive};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // transmitter stays on until shifter and buffer drain
  assign tx_eff = ctlb_q[ucc_pkg::B_TX_ON] |
    (tx_was_q & (tx_shift_busy | ~tx_empty_flag));

  // holds the transmitter on only if it was on before
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tx_was_q <= 1'b0;
    end else begin
      tx_was_q <= tx_eff;
    end
  end

  // transmission window, opened the cycle after tx_start
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tx_active_q <= 1'b0;
    end else if (tx_start) begin
      tx_active_q <= 1'b1;
    end else if (tx_done) begin
      tx_active_q <= 1'b0;
    end
  end

  // pin only drives in the tx_start cycle and inside the window in that mode
  assign tx_drive = tx_eff &
    (~ctla_q[ucc_pkg::B_HD_HI] | tx_active_q | tx_start);

  // line outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tx_pin_out <= 1'b1;
      tx_pin_oe <= 1'b0;
      tx_direction_pin <= 1'b0;
    end else begin
      if (ctlb_q[ucc_pkg::B_OD_EN]) begin
        tx_pin_out <= 1'b0;
        tx_pin_oe <= tx_drive & ~tx_serial;
      end else begin
        tx_pin_out <= tx_serial;
        tx_pin_oe <= tx_drive;
      end
      tx_direction_pin <= ctla_q[ucc_pkg::B_HD_LO] & (tx_start | (tx_active_q & ~tx_done));
    end
  end

  assign rx_src = ctla_q[ucc_pkg::B_LOOP] ? tx_serial : rx_pin;

  // receiver side
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rx_line <= 1'b1;
      rx_prev_q <= 1'b1;
      rx_flush <= 1'b1;
      autobaud_reset <= 1'b1;
      rx_frame_accept <= 1'b0;
      wake_req <= 1'b0;
    end else begin
      rx_line <= rx_src;
      rx_prev_q <= rx_src;
      // flush while receiver is off, auto-baud reset too if an auto-baud mode is set
      rx_flush <= ~ctlb_q[ucc_pkg::B_RX_ON];
      autobaud_reset <= ~ctlb_q[ucc_pkg::B_RX_ON] & autobaud;
      // drop non-address frames in multiprocessor mode
      rx_frame_accept <= rx_frame_valid & ctlb_q[ucc_pkg::B_RX_ON] &
        (~ctlb_q[ucc_pkg::B_MP_EN] | rx_frame_addr);
      wake_req <= ctlb_q[ucc_pkg::B_SFD_EN] & ~master_spi_mode & rx_prev_q & ~rx_src;
    end
  end

  assign pair_diff = (sync_pair_samples > ucc_pkg::SYNC_PAIR_NOM) ?
    6'(sync_pair_samples - ucc_pkg::SYNC_PAIR_NOM) :
    6'(ucc_pkg::SYNC_PAIR_NOM - sync_pair_samples);

  always_ff @(posedge ref_clk) begin
    if (!rst_b || !ctlb_q[ucc_pkg::B_RX_ON] || !autobaud) begin
      sync_cnt_q <= 4'h0;
      pair_err_q <= 1'b0;
      sync_ok <= 1'b0;
      sync_bad <= 1'b0;
    end else begin
      sync_ok <= 1'b0;
      sync_bad <= 1'b0;
      if (sync_bit_pair && sync_cnt_q < ucc_pkg::SYNC_BITS) begin
        sync_cnt_q <= sync_cnt_q + 4'h2;
        if (ctlb_q[ucc_pkg::B_RXM_LO] && pair_diff > ucc_pkg::SYNC_PAIR_TOL) begin
          pair_err_q <= 1'b1;
        end
      end
      if (sync_char_valid) begin
        sync_cnt_q <= 4'h0;
        pair_err_q <= 1'b0;
        if (ctlb_q[ucc_pkg::B_RXM_LO]) begin
          // constrained: value and pairs must both hold
          sync_ok <= ~pair_err_q & (sync_char == ucc_pkg::SYNC_VALUE) &
            (sync_cnt_q == ucc_pkg::SYNC_BITS);
          sync_bad <= pair_err_q | (sync_char != ucc_pkg::SYNC_VALUE) |
            (sync_cnt_q != ucc_pkg::SYNC_BITS);
        end else begin
          sync_ok <= (sync_cnt_q == ucc_pkg::SYNC_BITS);
          sync_bad <= (sync_cnt_q != ucc_pkg::SYNC_BITS);
        end
      end
    end
  end

  // decoded configuration
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cfg <= '0;
    end else begin
      cfg.rx_on <= ctlb_q[ucc_pkg::B_RX_ON];
      cfg.tx_on <= tx_eff;
      cfg.loopback_en <= ctla_q[ucc_pkg::B_LOOP];
      cfg.multiproc_filter_en <= ctlb_q[ucc_pkg::B_MP_EN];
      cfg.receiver_speed_mode <= ucc_pkg::ucc_rxm_e'(ctlb_q[ucc_pkg::B_RXM_HI:ucc_pkg::B_RXM_LO]);
      cfg.comm_mode <= ucc_pkg::ucc_cm_e'(frm_async_q[B_CM_HI_L:B_CM_LO_L]);
      // parity, reserved code treated as off
      cfg.parity_select <= (frm_async_q[ucc_pkg::B_PAR_HI] && !master_spi_mode) ?
        frm_async_q[ucc_pkg::B_PAR_HI:ucc_pkg::B_PAR_LO] : ucc_pkg::PAR_OFF;
      cfg.stop_bit_count <= frm_async_q[ucc_pkg::B_STOP];
      cfg.char_size <= frm_async_q[ucc_pkg::B_CS_HI:ucc_pkg::B_CS_LO];
      // character size decode, reserved codes fall back to eight
      case (frm_async_q[ucc_pkg::B_CS_HI:ucc_pkg::B_CS_LO])
        ucc_pkg::CS_9L, ucc_pkg::CS_9H: cfg.data_bits <= 4'h9;
        3'h4, 3'h5: cfg.data_bits <= 4'h8;
        default: cfg.data_bits <= 4'h5 + {1'b0, frm_async_q[ucc_pkg::B_CS_HI:ucc_pkg::B_CS_LO]};
      endcase
      cfg.nine_bit_high_first <=
        (frm_async_q[ucc_pkg::B_CS_HI:ucc_pkg::B_CS_LO] == ucc_pkg::CS_9H);
      cfg.spi_bit_order <= master_spi_mode & frm_spi_q[ucc_pkg::B_ORDER];
      cfg.spi_clock_phase <= master_spi_mode & frm_spi_q[ucc_pkg::B_PHASE];
      // double speed only in asynchronous modes
      if (frm_async_q[B_CM_HI_L:B_CM_LO_L] == ucc_pkg::UCC_CM_SYNC || master_spi_mode) begin
        cfg.baud_divisor <= {1'b0, ucc_pkg::DIV_SYNC};
      end else if (ctlb_q[ucc_pkg::B_RXM_HI:ucc_pkg::B_RXM_LO] == ucc_pkg::UCC_RXM_DOUBLE) begin
        cfg.baud_divisor <= ucc_pkg::DIV_DOUBLE;
      end else begin
        cfg.baud_divisor <= ucc_pkg::DIV_NORMAL;
      end
    end
  end

  // interrupt requests per vector
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq <= '0;
    end else begin
      // receive vector OR of enabled causes
      irq.receive_vector <= (ctla_q[ucc_pkg::B_RXC_IE] & rx_complete_flag) |
        (ctla_q[ucc_pkg::B_SF_IE] & wake_req) |
        (ctla_q[ucc_pkg::B_ABE_IE] & bad_sync_flag);
      irq.transmit_done_vector <= ctla_q[ucc_pkg::B_TXC_IE] & tx_complete_flag;
      irq.tx_empty_vector <= ctla_q[ucc_pkg::B_DRE_IE] & tx_empty_flag;
    end
  end
endmodule : ucc_top

// ### bench/ucc_chk.sv
/* Port assertions for ucc_top.
   Assumes one clock, synchronous active-low reset, bound to ucc_top. */
`timescale 1ns/1ns
module ucc_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // register writes
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  // engine side
  input wire logic rx_complete_flag,
  input wire logic tx_complete_flag,
  input wire logic tx_empty_flag,
  input wire logic bad_sync_flag,
  input wire logic tx_start,
  input wire logic tx_done,
  input wire logic tx_serial,
  // watched outputs
  input wire logic tx_pin_out,
  input wire logic tx_pin_oe,
  input wire logic tx_direction_pin,
  input wire logic rx_line,
  input wire logic rx_flush,
  input wire logic wake_req,
  input wire ucc_pkg::ucc_cfg_s cfg,
  input wire ucc_pkg::ucc_irq_s irq
);
  logic [7:0] ila_q;
  logic [7:0] ena_q;
  // copy of the two control registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ila_q <= 8'h00;
      ena_q <= 8'h00;
    end else if (reg_wr) begin
      if (reg_addr == ucc_pkg::OFS_INT_LINE) ila_q <= reg_wdata;
      if (reg_addr == ucc_pkg::OFS_ENA_MODE) ena_q <= reg_wdata;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_rx_vector_or:
    assert property ($past((ila_q[7] & rx_complete_flag) | (ila_q[2] & bad_sync_flag))
      |-> irq.receive_vector) else $error("receive vector missing");
  a_txc_vector:
    assert property (irq.transmit_done_vector == $past(ila_q[6] & tx_complete_flag))
      else $error("transmit done vector wrong");
  a_dre_vector:
    assert property (irq.tx_empty_vector == $past(ila_q[5] & tx_empty_flag))
      else $error("empty vector wrong");
  a_start_irq:
    assert property (wake_req && ila_q[4] |-> ##[0:1] irq.receive_vector)
      else $error("start frame vector missing");
  a_loop_source:
    assert property ($past(cfg.loopback_en) && cfg.loopback_en |-> rx_line == $past(tx_serial))
      else $error("loop line not from transmitter");
  a_dir_lead:
    assert property (tx_start && ila_q[0] && $past(ila_q[0]) |-> ##[0:1] tx_direction_pin)
      else $error("direction pin late");
  a_dir_drop:
    assert property (tx_done && ila_q[0] ##1 !tx_start [*2] |-> !tx_direction_pin)
      else $error("direction pin stuck high");
  a_flush_off:
    assert property (!$past(cfg.rx_on) && !cfg.rx_on |-> rx_flush)
      else $error("no flush with receiver off");
  a_od_low_only:
    assert property ($past(ena_q[3], 2) && $past(ena_q[3]) |-> !(tx_pin_oe && tx_pin_out))
      else $error("open drain drove high");
  a_div_double:
    assert property (cfg.comm_mode == ucc_pkg::UCC_CM_ASYNC
      && cfg.receiver_speed_mode == ucc_pkg::UCC_RXM_DOUBLE
      |-> cfg.baud_divisor == ucc_pkg::DIV_DOUBLE) else $error("double speed divisor wrong");
endmodule : ucc_chk
bind ucc_top ucc_chk u_chk (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
  .rx_complete_flag, .tx_complete_flag, .tx_empty_flag, .bad_sync_flag, .tx_start, .tx_done,
  .tx_serial, .tx_pin_out, .tx_pin_oe, .tx_direction_pin, .rx_line, .rx_flush, .wake_req,
  .cfg, .irq);

// ### bench/ucc_node.sv
/* Remote serial node on the line.
   Assumes the bench commands its line level; the shared line has a pull-up. */
`timescale 1ns/1ns
module ucc_node (
  // clock and command
  input wire logic ref_clk,
  input wire logic drive_low,
  // line from the block
  input wire logic tx_pin_out,
  input wire logic tx_pin_oe,
  // line levels seen
  output logic rx_pin = 1'b1,
  output logic tx_line
);
  assign tx_line = tx_pin_oe ? tx_pin_out : 1'b1;
  always @(posedge ref_clk) rx_pin <= !drive_low;
endmodule : ucc_node

// ### bench/tb.sv
/* Self-checking bench for ucc_top with a remote node model.
   Assumes 250 MHz ref_clk and outputs settled two cycles after a write. */
`timescale 1ns/1ns
module tb;
  localparam logic [3:0] CA = ucc_pkg::OFS_INT_LINE;
  localparam logic [3:0] CB = ucc_pkg::OFS_ENA_MODE;
  localparam logic [3:0] CC = ucc_pkg::OFS_FRAME;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [3:0] flg = 4'h4;
  logic tx_shift_busy = 1'b0, tx_start = 1'b0, tx_done = 1'b0, tx_serial = 1'b1;
  logic rx_frame_valid = 1'b0, rx_frame_addr = 1'b0, sync_bit_pair = 1'b0;
  logic sync_char_valid = 1'b0, drive_low = 1'b0;
  logic [5:0] sync_pair_samples = 6'h00;
  logic [7:0] sync_char = 8'h00;
  logic [7:0] reg_rdata;
  logic rx_pin, tx_pin_out, tx_pin_oe, tx_direction_pin, rx_line, rx_flush, autobaud_reset;
  logic rx_frame_accept, sync_ok, sync_bad, wake_req, tx_line;
  ucc_pkg::ucc_cfg_s cfg;
  ucc_pkg::ucc_irq_s irq;
  int miscompares = 0;
  int n_tests = 0;
  int c_ok = 0, c_bad = 0, c_wk = 0, c_acc = 0, c_rv = 0;
  ucc_top dut (.ref_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .rx_complete_flag(flg[0]), .tx_complete_flag(flg[1]), .tx_empty_flag(flg[2]),
    .bad_sync_flag(flg[3]), .tx_shift_busy, .tx_start, .tx_done, .tx_serial, .rx_frame_valid,
    .rx_frame_addr, .sync_bit_pair, .sync_pair_samples, .sync_char_valid, .sync_char, .rx_pin,
    .tx_pin_in(tx_line), .tx_pin_out, .tx_pin_oe, .tx_direction_pin, .rx_line, .rx_flush,
    .autobaud_reset, .rx_frame_accept, .sync_ok, .sync_bad, .wake_req, .cfg, .irq);
  ucc_node node (.ref_clk, .drive_low, .tx_pin_out, .tx_pin_oe, .rx_pin, .tx_line);
  always #2 ref_clk = ~ref_clk;
  // one count per output pulse
  always @(posedge ref_clk) begin
    c_ok += sync_ok;
    c_bad += sync_bad;
    c_wk += wake_req;
    c_acc += rx_frame_accept;
    c_rv += irq.receive_vector;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chb(input string nm, input logic e, input logic g);
    chk(nm, {7'h00, e}, {7'h00, g});
  endtask : chb
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    cyc(2);
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask : rd
  task automatic t_regs;
    rd(CA, ucc_pkg::RST_INT_LINE, "ctla_reset");
    rd(CC, ucc_pkg::RST_FRAME_ASYNC, "frame_reset");
    wr(CB, 8'hFF);
    rd(CB, ucc_pkg::MASK_ENA_MODE, "ctlb_unused_bit");
    rd(4'hF, 8'h00, "unmapped");
    wr(CB, 8'h00);
  endtask : t_regs
  task automatic t_irq;
    logic [7:0] en [4] = '{8'h80, 8'h40, 8'h20, 8'h04};
    logic [2:0] ex [4] = '{3'h4, 3'h2, 3'h1, 3'h4};
    foreach (en[i]) begin
      wr(CA, en[i]);
      @(posedge ref_clk);
      flg <= 4'h1 << i;
      cyc(2);
      chk("irq_on", {5'h00, ex[i]}, {5'h00, irq});
      wr(CA, 8'hE4 & ~en[i]);
      chk("irq_masked", 8'h00, {5'h00, irq});
    end
    wr(CA, 8'h00);
    @(posedge ref_clk);
    flg <= 4'h4;
  endtask : t_irq
  task automatic t_loop;
    wr(CA, 8'h08);
    @(posedge ref_clk);
    tx_serial <= 1'b0;
    cyc(3);
    chb("loop_line", 1'b0, rx_line);
    @(posedge ref_clk);
    tx_serial <= 1'b1;
    drive_low <= 1'b1;
    cyc(3);
    chb("loop_ignores_pin", 1'b1, rx_line);
    wr(CA, 8'h00);
    chb("pin_line", 1'b0, rx_line);
    @(posedge ref_clk);
    drive_low <= 1'b0;
  endtask : t_loop
  task automatic t_hdx;
    wr(CA, 8'h03);
    wr(CB, 8'h40);
    chb("oe_idle", 1'b0, tx_pin_oe);
    @(posedge ref_clk);
    tx_start <= 1'b1;
    @(posedge ref_clk);
    tx_start <= 1'b0;
    #1;
    chb("dir_lead", 1'b1, tx_direction_pin);
    chb("oe_lead", 1'b1, tx_pin_oe);
    cyc(3);
    @(posedge ref_clk);
    tx_done <= 1'b1;
    @(posedge ref_clk);
    tx_done <= 1'b0;
    cyc(1);
    chb("dir_drop", 1'b0, tx_direction_pin);
    chb("oe_drop", 1'b0, tx_pin_oe);
    wr(CA, 8'h00);
  endtask : t_hdx
  task automatic t_txoff;
    @(posedge ref_clk);
    flg <= 4'h0;
    tx_shift_busy <= 1'b1;
    wr(CB, 8'h00);
    chb("tx_held", 1'b1, cfg.tx_on);
    rd(CB, 8'h40, "tx_on_read");
    @(posedge ref_clk);
    flg <= 4'h4;
    tx_shift_busy <= 1'b0;
    cyc(3);
    chb("tx_off", 1'b0, cfg.tx_on);
    chb("tx_released", 1'b0, tx_pin_oe);
  endtask : t_txoff
  task automatic t_od;
    wr(CB, 8'h48);
    cyc(1);
    chb("od_release", 1'b1, tx_line);
    chb("od_oe_off", 1'b0, tx_pin_oe);
    @(posedge ref_clk);
    tx_serial <= 1'b0;
    cyc(3);
    chb("od_pull_low", 1'b0, tx_line);
    @(posedge ref_clk);
    tx_serial <= 1'b1;
    wr(CB, 8'h00);
  endtask : t_od
  task automatic t_sync;
    logic [22:0] tb_row [5] = '{{1'b1, 8'h86, 6'h20, 8'h55}, {1'b1, 8'h86, 6'h26, 8'h55},
      {1'b0, 8'h86, 6'h27, 8'h55}, {1'b0, 8'h86, 6'h20, 8'h54}, {1'b1, 8'h84, 6'h3A, 8'h3C}};
    int n0, n1;
    foreach (tb_row[i]) begin
      wr(CB, tb_row[i][21:14]);
      n0 = c_ok;
      n1 = c_bad;
      @(posedge ref_clk);
      repeat (4) begin
        sync_bit_pair <= 1'b1;
        sync_pair_samples <= tb_row[i][13:8];
        @(posedge ref_clk);
        sync_bit_pair <= 1'b0;
        @(posedge ref_clk);
      end
      sync_char_valid <= 1'b1;
      sync_char <= tb_row[i][7:0];
      @(posedge ref_clk);
      sync_char_valid <= 1'b0;
      cyc(3);
      chb("sync_ok", tb_row[i][22], 1'(c_ok - n0));
      chb("sync_bad", !tb_row[i][22], 1'(c_bad - n1));
      // receiver off with the auto-baud mode kept
      wr(CB, tb_row[i][21:14] & 8'h7F);
      chb("autobaud_reset", 1'b1, autobaud_reset);
    end
  endtask : t_sync
  task automatic t_wake_mp;
    int n0, n1;
    wr(CA, 8'h10);
    wr(CB, 8'h91);
    n0 = c_wk;
    n1 = c_rv;
    @(posedge ref_clk);
    drive_low <= 1'b1;
    cyc(5);
    chb("wake", 1'b1, 1'(c_wk - n0));
    chb("start_irq", 1'b1, 1'(c_rv - n1));
    @(posedge ref_clk);
    rx_frame_valid <= 1'b1;
    @(posedge ref_clk);
    rx_frame_addr <= 1'b1;
    @(posedge ref_clk);
    rx_frame_valid <= 1'b0;
    cyc(3);
    chb("mp_filter", 1'b1, 1'(c_acc));
    @(posedge ref_clk);
    drive_low <= 1'b0;
    rx_frame_addr <= 1'b0;
    wr(CB, 8'h00);
    wr(CA, 8'h00);
  endtask : t_wake_mp
  task automatic t_cfg;
    wr(CC, 8'h00);
    chk("bits_5", 8'h05, {4'h0, cfg.data_bits});
    wr(CC, 8'h3F);
    chk("bits_9h", 8'h09, {4'h0, cfg.data_bits});
    chb("stop_two", 1'b1, cfg.stop_bit_count);
    chk("parity_odd", 8'h03, {6'h00, cfg.parity_select});
    wr(CC, 8'hC4);
    rd(CC, 8'hC4, "spi_layout");
    chb("lsb_first", 1'b1, cfg.spi_bit_order);
    wr(CC, 8'hC2);
    chb("msb_first", 1'b0, cfg.spi_bit_order);
    chb("phase_trail", 1'b1, cfg.spi_clock_phase);
    wr(CC, 8'h03);
    wr(CB, 8'h02);
    chk("div_double", 8'h08, {3'h0, cfg.baud_divisor});
    wr(CB, 8'h00);
    chk("div_normal", 8'h10, {3'h0, cfg.baud_divisor});
  endtask : t_cfg
  task automatic tally_and_finish;
    if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    t_regs;
    t_irq;
    t_loop;
    t_hdx;
    t_txoff;
    t_od;
    t_sync;
    t_wake_mp;
    t_cfg;
    tally_and_finish;
  end
  initial begin
    #40000;
    miscompares++;
    tally_and_finish;
  end
endmodule : tb
